/* File: logic/buf_fault_tracker.sv */
// Occupancy tracker for one mapping buffer; flags overflow and underflow events.
// Assumes push and pop are single-cycle strobes from logic on the same clock.
`default_nettype none

module buf_fault_tracker #(
    parameter int DEPTH = 16
) (
    input wire logic clk, // System clock
    input wire logic rst_n, // Synchronised reset, active low
    input wire logic push, // Buffer write strobe
    input wire logic pop, // Buffer read strobe
    output logic ovf_evt, // Push refused, buffer full
    output logic udf_evt // Pop refused, buffer empty
);

    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    logic [CW-1:0] count_q;
    logic full;
    logic empty;

    assign full = (count_q == FULL);
    assign empty = (count_q == '0);

    // A simultaneous push and pop passes through, so neither fault applies
    assign ovf_evt = push && !pop && full; // R16
    assign udf_evt = pop && !push && empty; // R16

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= '0;
        end else if (push && !pop && !full) begin
            count_q <= count_q + CW'(1);
        end else if (pop && !push && !empty) begin
            count_q <= count_q - CW'(1);
        end
    end

endmodule

`default_nettype wire

/* File: logic/mapregs_defines.svh */
// Constants for the mapping-buffer and Ethernet status register bank.
// Assumes a 32-bit classic Wishbone slave with byte addresses on ADR_I.
//
// Function
// [R1] One RW transmit enable bit per interface, reset all ones, drives its output.
// [R2] Receive buffer overflow flags in low bits, underflow from bit 16, clear on read.
// [R3] Transmit buffer overflow flags in low bits, underflow from bit 16, clear on read.
// [R4] Interfaces 16 and up report in the next status word, four bytes higher.
// [R5] Number of interfaces is a build parameter, at most 24.
// [R6] Ethernet words decoded 0x200 to 0x24C, 0x228 and 0x238-0x240 unused.
// [R7] Receive status bit 0: at least one full word ready to read.
// [R8] Receive status bit 6: an eight-word block is available.
// [R9] Receive status bit 5: end of packet stored and ready.
// [R10] Receive status bits 4:3 give valid bytes of last word, code plus one.
// [R11] Receive status bit 2: current receive packet aborted.
// [R12] Receive status bit 1: next ready word holds the final byte.
// [R13] Transmit status bit 2: can accept an eight-word block.
// [R14] Transmit status bit 1: current transmit packet aborted.
// [R15] Transmit status bit 0: can accept at least one word.
// [R16] Each mapping buffer is 16 deep; overflow and underflow judged against it.
// [R17] Fault flags stay set after an event until their register is read.
`ifndef MAPREGS_DEFINES_SVH
`define MAPREGS_DEFINES_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define OFS_MAP_TX_LANE_ENABLE 12'h160
`define OFS_MAP_RX_FAULT_LO 12'h180
`define OFS_MAP_RX_FAULT_HI 12'h184
`define OFS_MAP_TX_FAULT_LO 12'h1a0
`define OFS_MAP_TX_FAULT_HI 12'h1a4
`define OFS_ENET_RX_STATE 12'h200
`define OFS_ENET_TX_STATE 12'h204
`define OFS_ENET_SETUP_A 12'h208
`define OFS_ENET_SETUP_B 12'h20c
`define OFS_ENET_RX_CMD 12'h210
`define OFS_ENET_RX_WORD 12'h214
`define OFS_ENET_RX_WORD_STALL 12'h218
`define OFS_ENET_TX_CMD 12'h21c
`define OFS_ENET_TX_WORD 12'h220
`define OFS_ENET_TX_WORD_STALL 12'h224
`define OFS_ENET_GAP_A 12'h228
`define OFS_ENET_ADDR_UPPER 12'h22c
`define OFS_ENET_ADDR_LOWER 12'h230
`define OFS_ENET_GROUP_FILTER 12'h234
`define OFS_ENET_GAP_B_FIRST 12'h238
`define OFS_ENET_GAP_B_LAST 12'h240
`define OFS_ENET_FWD_SETUP 12'h244
`define OFS_ENET_RX_FRAMES 12'h248
`define OFS_ENET_TX_FRAMES 12'h24c
`define OFS_IRQ_STATUS 12'h280
`define OFS_IRQ_CLEAR 12'h284
`define OFS_IRQ_ENABLE 12'h288

// ****************************************************************
// Field positions and sizes
// ****************************************************************
`define MAP_IF_MAX 24
`define MAP_WORD_IFS 16
`define MAP_UDF_LSB 16
`define MAP_BUF_DEPTH 16
`define ENET_RX_STATE_W 7
`define ENET_TX_STATE_W 3
`define IRQ_W 5
`define IRQ_RX_FAULT 0
`define IRQ_TX_FAULT 1
`define IRQ_RX_END 2
`define IRQ_RX_ABORT 3
`define IRQ_TX_ABORT 4

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_TX_LANE_ENABLE 24'hffffff
`define RST_FLAGS 24'h000000
`define RST_IRQ 5'h00
`define RST_READ_DATA 32'h00000000

`endif

/* File: logic/mapregs_pkg.sv */
// Types shared by the register bank and its users.
// Assumes mapregs_defines.svh is on the include path.
`include "mapregs_defines.svh"
`default_nettype none

package mapregs_pkg;

    // Receive engine status, packed in register bit order 6..0
    typedef struct packed {
        logic ready_block;
        logic ready_end;
        logic [1:0] last_len;
        logic abort;
        logic eop;
        logic ready;
    } enet_rx_state_t;

    // Transmit engine status, packed in register bit order 2..0
    typedef struct packed {
        logic ready_block;
        logic abort;
        logic ready;
    } enet_tx_state_t;

    // One classic Wishbone request as seen by the slave
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [11:0] adr;
        logic [31:0] dat;
    } wb_req_t;

endpackage

`default_nettype wire

/* File: logic/mapregs_top.sv */
// Register bank: mapping buffer enables and fault flags, Ethernet status words,
// and an interrupt block, behind a classic Wishbone slave.
// Assumes buffer strobes and Ethernet status come from logic on SYS_CLK.
//
// Implementation choice: the Wishbone interface to the registers.
`include "mapregs_defines.svh"
`default_nettype none

module mapregs_top #(
    parameter int N_MAP = 7 // R5
) (
    input wire logic SYS_CLK, // 40 MHz system clock
    input wire logic RESETN, // Asynchronous reset, active low
    input wire logic CYC_I, // Wishbone cycle
    input wire logic STB_I, // Wishbone strobe
    input wire logic WE_I, // Wishbone write enable
    input wire logic [3:0] SEL_I, // Wishbone byte selects
    input wire logic [11:0] ADR_I, // Wishbone byte address
    input wire logic [31:0] DAT_I, // Wishbone write data
    output logic [31:0] DAT_O, // Wishbone read data
    output logic ACK_O, // Wishbone acknowledge
    output logic ERR_O, // Wishbone error, unmapped address
    output logic IRQ, // Level interrupt
    output logic [N_MAP-1:0] MAP_TX_EN, // Per-interface transmit enable
    input wire logic [N_MAP-1:0] MAP_RX_PUSH, // Receive buffer write strobes
    input wire logic [N_MAP-1:0] MAP_RX_POP, // Receive buffer read strobes
    input wire logic [N_MAP-1:0] MAP_TX_PUSH, // Transmit buffer write strobes
    input wire logic [N_MAP-1:0] MAP_TX_POP, // Transmit buffer read strobes
    input wire mapregs_pkg::enet_rx_state_t ENET_RX_STATE, // Receive engine status
    input wire mapregs_pkg::enet_tx_state_t ENET_TX_STATE // Transmit engine status
);

    // Interfaces beyond the maximum are not tracked; their enables are high in reset and low from the first clock after it
    localparam int NA = (N_MAP > `MAP_IF_MAX) ? `MAP_IF_MAX : N_MAP; // R5
    localparam int MX = `MAP_IF_MAX;

    // ****************************************************************
    // Reset release
    // ****************************************************************
    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // ****************************************************************
    // Bus request decode
    // ****************************************************************
    mapregs_pkg::wb_req_t req;
    logic ack_q;
    logic err_q;
    logic take;
    logic hit;
    logic rd_take;
    logic wr_take;
    logic [31:0] rdata;
    logic [31:0] wmask;

    assign req = '{cyc: CYC_I, stb: STB_I, we: WE_I, sel: SEL_I, adr: ADR_I, dat: DAT_I};
    // One request per handshake: nothing is taken while an answer stands
    assign take = req.cyc && req.stb && !ack_q && !err_q;
    assign rd_take = take && hit && !req.we;
    assign wr_take = take && hit && req.we;
    assign wmask = {{8{req.sel[3]}}, {8{req.sel[2]}}, {8{req.sel[1]}}, {8{req.sel[0]}}};

    // ****************************************************************
    // Buffer fault trackers
    // ****************************************************************
    logic [MX-1:0] rx_ovf_evt;
    logic [MX-1:0] rx_udf_evt;
    logic [MX-1:0] tx_ovf_evt;
    logic [MX-1:0] tx_udf_evt;

    genvar gi;
    generate
        for (gi = 0; gi < MX; gi = gi + 1) begin : g_if
            if (gi < NA) begin : g_on
                buf_fault_tracker #(
                    .DEPTH(`MAP_BUF_DEPTH)
                ) u_rx (
                    .clk(SYS_CLK),
                    .rst_n(rst_n_q),
                    .push(MAP_RX_PUSH[gi]),
                    .pop(MAP_RX_POP[gi]),
                    .ovf_evt(rx_ovf_evt[gi]),
                    .udf_evt(rx_udf_evt[gi])
                );
                buf_fault_tracker #(
                    .DEPTH(`MAP_BUF_DEPTH)
                ) u_tx (
                    .clk(SYS_CLK),
                    .rst_n(rst_n_q),
                    .push(MAP_TX_PUSH[gi]),
                    .pop(MAP_TX_POP[gi]),
                    .ovf_evt(tx_ovf_evt[gi]),
                    .udf_evt(tx_udf_evt[gi])
                );
            end else begin : g_off
                assign rx_ovf_evt[gi] = 1'b0;
                assign rx_udf_evt[gi] = 1'b0;
                assign tx_ovf_evt[gi] = 1'b0;
                assign tx_udf_evt[gi] = 1'b0;
            end
        end
    endgenerate

    // ****************************************************************
    // Sticky fault flags, cleared by a read of their word
    // ****************************************************************
    logic [MX-1:0] rx_ovf_q;
    logic [MX-1:0] rx_udf_q;
    logic [MX-1:0] tx_ovf_q;
    logic [MX-1:0] tx_udf_q;
    logic [MX-1:0] lo_part;
    logic [MX-1:0] hi_part;
    logic rd_rx_lo;
    logic rd_rx_hi;
    logic rd_tx_lo;
    logic rd_tx_hi;

    assign lo_part = {{(MX - `MAP_WORD_IFS){1'b0}}, {`MAP_WORD_IFS{1'b1}}}; // R4
    assign hi_part = ~lo_part; // R4
    assign rd_rx_lo = rd_take && (req.adr == `OFS_MAP_RX_FAULT_LO);
    assign rd_rx_hi = rd_take && (req.adr == `OFS_MAP_RX_FAULT_HI);
    assign rd_tx_lo = rd_take && (req.adr == `OFS_MAP_TX_FAULT_LO);
    assign rd_tx_hi = rd_take && (req.adr == `OFS_MAP_TX_FAULT_HI);

    // An event in the cycle of the clearing read survives that read
    always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rx_ovf_q <= `RST_FLAGS;
            rx_udf_q <= `RST_FLAGS;
        end else begin
            rx_ovf_q <= (rx_ovf_q & ~(({MX{rd_rx_lo}} & lo_part) | ({MX{rd_rx_hi}} & hi_part)))
                | rx_ovf_evt; // R2 R17
            rx_udf_q <= (rx_udf_q & ~(({MX{rd_rx_lo}} & lo_part) | ({MX{rd_rx_hi}} & hi_part)))
                | rx_udf_evt; // R2 R17
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            tx_ovf_q <= `RST_FLAGS;
            tx_udf_q <= `RST_FLAGS;
        end else begin
            tx_ovf_q <= (tx_ovf_q & ~(({MX{rd_tx_lo}} & lo_part) | ({MX{rd_tx_hi}} & hi_part)))
                | tx_ovf_evt; // R3 R17
            tx_udf_q <= (tx_udf_q & ~(({MX{rd_tx_lo}} & lo_part) | ({MX{rd_tx_hi}} & hi_part)))
                | tx_udf_evt; // R3 R17
        end
    end

    // ****************************************************************
    // Transmit lane enables
    // ****************************************************************
    logic [MX-1:0] lane_en_q;
    logic [MX-1:0] lane_valid;

    assign lane_valid = MX'((1 << NA) - 1);

    always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            lane_en_q <= `RST_TX_LANE_ENABLE & MX'((1 << NA) - 1); // R1
        end else if (wr_take && (req.adr == `OFS_MAP_TX_LANE_ENABLE)) begin
            lane_en_q <= ((lane_en_q & ~wmask[MX-1:0]) | (req.dat[MX-1:0] & wmask[MX-1:0]))
                & lane_valid; // R1
        end
    end

    // Enables leave through a flop that follows the register
    logic [N_MAP-1:0] map_tx_en_q;

    always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            map_tx_en_q <= '1; // R1
        end else begin
            for (int i = 0; i < N_MAP; i = i + 1) begin
                map_tx_en_q[i] <= (i < MX) ? lane_en_q[i % MX] : 1'b0; // R1
            end
        end
    end

    // ****************************************************************
    // Ethernet engine status
    // ****************************************************************
    mapregs_pkg::enet_rx_state_t enet_rx_q;
    mapregs_pkg::enet_tx_state_t enet_tx_q;

    // Status tracks the engines one cycle late; the flop also gives edge detection
    always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            enet_rx_q <= '0;
            enet_tx_q <= '0;
        end else begin
            enet_rx_q <= ENET_RX_STATE; // R7 R8 R9 R10 R11 R12
            enet_tx_q <= ENET_TX_STATE; // R13 R14 R15
        end
    end

    // ****************************************************************
    // Interrupt status, clear and enable
    // ****************************************************************
    logic [`IRQ_W-1:0] irq_evt;
    logic [`IRQ_W-1:0] irq_stat_q;
    logic [`IRQ_W-1:0] irq_en_q;
    logic [`IRQ_W-1:0] irq_clr;
    logic irq_q;

    always_comb begin
        irq_evt = '0;
        irq_evt[`IRQ_RX_FAULT] = |(rx_ovf_evt | rx_udf_evt);
        irq_evt[`IRQ_TX_FAULT] = |(tx_ovf_evt | tx_udf_evt);
        irq_evt[`IRQ_RX_END] = ENET_RX_STATE.ready_end && !enet_rx_q.ready_end;
        irq_evt[`IRQ_RX_ABORT] = ENET_RX_STATE.abort && !enet_rx_q.abort;
        irq_evt[`IRQ_TX_ABORT] = ENET_TX_STATE.abort && !enet_tx_q.abort;
    end

    assign irq_clr = (wr_take && (req.adr == `OFS_IRQ_CLEAR) && req.sel[0]) ? req.dat[`IRQ_W-1:0] : '0;

    always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            irq_stat_q <= `RST_IRQ;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_evt;
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            irq_en_q <= `RST_IRQ;
        end else if (wr_take && (req.adr == `OFS_IRQ_ENABLE) && req.sel[0]) begin
            irq_en_q <= req.dat[`IRQ_W-1:0];
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_stat_q & irq_en_q);
        end
    end

    // ****************************************************************
    // Read decode
    // ****************************************************************
    always_comb begin
        hit = 1'b1;
        rdata = `RST_READ_DATA;
        case (req.adr)
            `OFS_MAP_TX_LANE_ENABLE: begin
                rdata = {8'h00, lane_en_q};
            end
            `OFS_MAP_RX_FAULT_LO: begin
                rdata = {rx_udf_q[15:0], rx_ovf_q[15:0]}; // R2
            end
            `OFS_MAP_RX_FAULT_HI: begin
                rdata = {8'h00, rx_udf_q[23:16], 8'h00, rx_ovf_q[23:16]}; // R4
            end
            `OFS_MAP_TX_FAULT_LO: begin
                rdata = {tx_udf_q[15:0], tx_ovf_q[15:0]}; // R3
            end
            `OFS_MAP_TX_FAULT_HI: begin
                rdata = {8'h00, tx_udf_q[23:16], 8'h00, tx_ovf_q[23:16]}; // R4
            end
            `OFS_ENET_RX_STATE: begin
                rdata = {25'h0, enet_rx_q}; // R7 R8 R9 R10 R11 R12
            end
            `OFS_ENET_TX_STATE: begin
                rdata = {29'h0, enet_tx_q}; // R13 R14 R15
            end
            `OFS_ENET_SETUP_A, `OFS_ENET_SETUP_B, `OFS_ENET_RX_CMD, `OFS_ENET_RX_WORD,
            `OFS_ENET_RX_WORD_STALL, `OFS_ENET_TX_CMD, `OFS_ENET_TX_WORD, `OFS_ENET_TX_WORD_STALL,
            `OFS_ENET_ADDR_UPPER, `OFS_ENET_ADDR_LOWER, `OFS_ENET_GROUP_FILTER, `OFS_ENET_FWD_SETUP,
            `OFS_ENET_RX_FRAMES, `OFS_ENET_TX_FRAMES: begin
                // Decoded so software sees an answer; contents live in the Ethernet engine
                rdata = `RST_READ_DATA; // R6
            end
            `OFS_IRQ_STATUS: begin
                rdata = {27'h0, irq_stat_q};
            end
            `OFS_IRQ_CLEAR: begin
                rdata = `RST_READ_DATA;
            end
            `OFS_IRQ_ENABLE: begin
                rdata = {27'h0, irq_en_q};
            end
            default: begin
                // 0x228 and 0x238-0x240 fall here along with every other hole
                hit = 1'b0; // R6
            end
        endcase
        if (req.adr[1:0] != 2'b00) begin
            hit = 1'b0;
        end
    end

    // ****************************************************************
    // Bus answer
    // ****************************************************************
    logic [31:0] dat_q;

    always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ack_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            ack_q <= take && hit;
            err_q <= take && !hit;
        end
    end

    // Data is caught at the same edge that clears the flags, so the read shows them
    always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            dat_q <= `RST_READ_DATA;
        end else if (rd_take) begin
            dat_q <= rdata;
        end else begin
            dat_q <= `RST_READ_DATA;
        end
    end

    assign DAT_O = dat_q;
    assign ACK_O = ack_q;
    assign ERR_O = err_q;
    assign IRQ = irq_q;
    assign MAP_TX_EN = map_tx_en_q;

endmodule

`default_nettype wire

/* File: test/mapregs_checker.sv */
// Concurrent checks on the register bank's ports.
// Assumes it is bound into mapregs_top and sees only that module's ports.
`default_nettype none
module mapregs_checker #(
    parameter int N_MAP = 7
) (
    input wire logic SYS_CLK, // Clock
    input wire logic RESETN, // Reset, active low
    input wire logic CYC_I, // Cycle
    input wire logic STB_I, // Strobe
    input wire logic WE_I, // Write enable
    input wire logic [3:0] SEL_I, // Byte selects
    input wire logic [11:0] ADR_I, // Address
    input wire logic [31:0] DAT_I, // Write data
    input wire logic [31:0] DAT_O, // Read data
    input wire logic ACK_O, // Acknowledge
    input wire logic ERR_O, // Error
    input wire logic IRQ, // Interrupt
    input wire logic [N_MAP-1:0] MAP_TX_EN, // Lane enables
    input wire mapregs_pkg::enet_rx_state_t ENET_RX_STATE, // Receive status
    input wire mapregs_pkg::enet_tx_state_t ENET_TX_STATE // Transmit status
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Only interfaces 16..23 may show in an upper status word
    localparam int HN = ((N_MAP > 24) ? 24 : N_MAP) - 16;
    localparam logic [31:0] HM = (HN > 0) ? (((32'h1 << HN) - 32'h1) * 32'h00010001) : 32'h0;
    logic take;
    logic rd_hi_q;
    assign take = CYC_I && STB_I && !ACK_O && !ERR_O;
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rd_hi_q <= 1'b0;
        end else begin
            rd_hi_q <= take && !WE_I && (ADR_I == 12'h184 || ADR_I == 12'h1a4);
        end
    end
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RESETN);
    sequence s_read_at(a);
        take && !WE_I && ADR_I == a;
    endsequence
    sequence s_lane_write;
        take && WE_I && ADR_I == 12'h160 && SEL_I == 4'hf;
    endsequence
    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_answer_next: assert property (take |=> (ACK_O ^ ERR_O))
        else $error("request not answered in one cycle");
    a_answer_pulse: assert property ((ACK_O || ERR_O) |=> !(ACK_O || ERR_O))
        else $error("answer longer than one cycle");
    a_gap_error: assert property (take && ADR_I inside {12'h228, 12'h238, 12'h23c, 12'h240} |=> ERR_O)
        else $error("unused word not refused");
    a_misalign_error: assert property (take && ADR_I[1:0] != 2'h0 |=> ERR_O && DAT_O == 32'h0)
        else $error("misaligned access not refused");
    a_enet_word_ack: assert property (take && ADR_I[1:0] == 2'h0 && ADR_I inside {[12'h200:12'h224], 12'h22c,
        12'h230, 12'h234, [12'h244:12'h24c]} |=> ACK_O)
        else $error("mapped word not acknowledged");
    a_lane_follow: assert property (s_lane_write |=> ##1 MAP_TX_EN == $past(DAT_I[N_MAP-1:0], 2))
        else $error("enable outputs do not follow lane register");
    a_rx_state_read: assert property (s_read_at(12'h200) && ENET_RX_STATE == $past(ENET_RX_STATE)
        && ENET_RX_STATE == $past(ENET_RX_STATE, 2) |=> DAT_O == {25'h0, $past(ENET_RX_STATE)})
        else $error("receive status word wrong");
    a_tx_state_read: assert property (s_read_at(12'h204) && ENET_TX_STATE == $past(ENET_TX_STATE)
        && ENET_TX_STATE == $past(ENET_TX_STATE, 2) |=> DAT_O == {29'h0, $past(ENET_TX_STATE)})
        else $error("transmit status word wrong");
    a_hi_reserved: assert property (rd_hi_q && ACK_O |-> (DAT_O & ~HM) == 32'h0)
        else $error("upper status word has bits outside its interfaces");
endmodule
bind mapregs_top mapregs_checker #(.N_MAP(N_MAP)) i_chk (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .CYC_I(CYC_I),
    .STB_I(STB_I), .WE_I(WE_I), .SEL_I(SEL_I), .ADR_I(ADR_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
    .ERR_O(ERR_O), .IRQ(IRQ), .MAP_TX_EN(MAP_TX_EN), .ENET_RX_STATE(ENET_RX_STATE), .ENET_TX_STATE(ENET_TX_STATE));
`default_nettype wire

/* File: test/tb_top.sv */
// Self-checking bench for the register bank, 20 interfaces.
// Assumes the checker file binds itself into the design.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NM = 20;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [3:0] sel = 4'h0;
    logic [11:0] adr = 12'h000;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack, err, irq;
    logic [NM-1:0] tx_en;
    logic [NM-1:0] rxp = '0, rxq = '0, txp = '0, txq = '0;
    mapregs_pkg::enet_rx_state_t rxs = '0;
    mapregs_pkg::enet_tx_state_t txs = '0;
    int n_mismatch = 0;
    int checked = 0;
    logic [11:0] gaps [6] = '{12'h228, 12'h238, 12'h23c, 12'h240, 12'h202, 12'h300};
    logic [6:0] rxv [8] = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h18, 7'h20, 7'h40};
    initial forever #12.5 clk = ~clk;
    mapregs_top #(.N_MAP(NM)) i_dut (.SYS_CLK(clk), .RESETN(rst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
        .SEL_I(sel), .ADR_I(adr), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack), .ERR_O(err), .IRQ(irq),
        .MAP_TX_EN(tx_en), .MAP_RX_PUSH(rxp), .MAP_RX_POP(rxq), .MAP_TX_PUSH(txp), .MAP_TX_POP(txq),
        .ENET_RX_STATE(rxs), .ENET_TX_STATE(txs));
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic give_verdict;
        $display("Mismatches %0d, checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Holds the request until the edge that samples the answer
    task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
        output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && err !== 1'b1 && n < 50);
        r = rdat;
        e = err;
        if (n >= 50) n_mismatch++;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        wb(1'b0, a, 32'h0, 4'hf, r, e);
        chk({31'h0, e}, 32'h0);
        chk(r, exp);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        logic e;
        wb(1'b1, a, d, s, r, e);
        chk({31'h0, e}, 32'h0);
    endtask
    task automatic bad(input logic [11:0] a);
        logic [31:0] r;
        logic e;
        wb(1'b0, a, 32'h0, 4'hf, r, e);
        chk({31'h0, e}, 32'h1);
    endtask
    // Kind 0..3: receive push, receive pop, transmit push, transmit pop; held n edges
    task automatic strobe(input int k, input int i, input int n);
        @(posedge clk);
        case (k)
            0: rxp[i] <= 1'b1;
            1: rxq[i] <= 1'b1;
            2: txp[i] <= 1'b1;
            default: txq[i] <= 1'b1;
        endcase
        repeat (n) @(posedge clk);
        rxp <= '0;
        rxq <= '0;
        txp <= '0;
        txq <= '0;
    endtask
    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        give_verdict;
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk({12'h0, tx_en}, 32'h000fffff);
        rd(12'h160, 32'h000fffff);
        rd(12'h180, 32'h0);
        rd(12'h184, 32'h0);
        rd(12'h1a0, 32'h0);
        wr(12'h160, 32'hfff5a5a5, 4'hf);
        rd(12'h160, 32'h0005a5a5);
        wr(12'h160, 32'h0, 4'h2);
        rd(12'h160, 32'h000500a5);
        chk({12'h0, tx_en}, 32'h000500a5);
        strobe(0, 2, 16);
        strobe(0, 17, 16);
        rd(12'h180, 32'h0);
        rd(12'h184, 32'h0);
        strobe(0, 2, 1);
        strobe(0, 17, 1);
        repeat (3) @(posedge clk);
        rd(12'h180, 32'h00000004);
        rd(12'h184, 32'h00000002);
        rd(12'h180, 32'h0);
        strobe(1, 0, 1);
        rd(12'h180, 32'h00010000);
        strobe(3, 3, 1);
        strobe(3, 18, 1);
        rd(12'h1a0, 32'h00080000);
        rd(12'h1a4, 32'h00040000);
        strobe(2, 19, 17);
        rd(12'h1a4, 32'h00000008);
        for (int i = 0; i < 8; i++) begin
            rxs <= rxv[i];
            repeat (3) @(posedge clk);
            rd(12'h200, {25'h0, rxv[i]});
        end
        for (int i = 0; i < 3; i++) begin
            txs <= 3'h1 << i;
            repeat (3) @(posedge clk);
            rd(12'h204, 32'h1 << i);
        end
        rxs <= '0;
        wr(12'h200, 32'hffffffff, 4'hf);
        rd(12'h200, 32'h0);
        for (int i = 0; i < 6; i++) bad(gaps[i]);
        rd(12'h208, 32'h0);
        rd(12'h24c, 32'h0);
        wr(12'h284, 32'h1f, 4'h1);
        wr(12'h288, 32'h1, 4'hf);
        strobe(1, 1, 1);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        rd(12'h280, 32'h1);
        wr(12'h284, 32'h1, 4'h1);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        rd(12'h180, 32'h00020000);
        wr(12'h288, 32'h0, 4'hf);
        strobe(1, 1, 1);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        rd(12'h280, 32'h1);
        give_verdict;
    end
endmodule
`default_nettype wire
